// file: design/mic_defines.svh
// Register offsets, field positions, reset values and codes of the interrupt controller
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

`define MIC_ADDR_W 8
`define MIC_PORT_W 6
`define MIC_PC_W 9
`define MIC_NUM_SRC 3

`define MIC_OFF_FLAG 8'h00
`define MIC_OFF_ENABLE 8'h04
`define MIC_OFF_PWR_CTRL 8'h08
`define MIC_OFF_PWR_CTRL_ONE 8'h0c
`define MIC_OFF_CHG_SEL 8'h10
`define MIC_OFF_EXT_EDGE 8'h14
`define MIC_OFF_STATUS 8'h18

`define MIC_BIT_TIMER 0
`define MIC_BIT_PORT 1
`define MIC_BIT_EXT 2
`define MIC_BIT_EXT_SEL 6
`define MIC_BIT_GIE 7
`define MIC_BIT_EDGE 0
`define MIC_BIT_STAT_GIE 3
`define MIC_BIT_STAT_PEND 4

`define MIC_RST_FLAGS 3'h0
`define MIC_RST_ENABLES 3'h0
`define MIC_RST_CHG_SEL 6'h00
`define MIC_RST_VECTOR 9'h000

`define MIC_VEC_SOFT 9'h001
`define MIC_VEC_HW 9'h008

`define MIC_RESP_OKAY 2'b00
`define MIC_RESP_SLVERR 2'b10

`endif

// file: design/mic_pkg.sv
// Types shared by the interrupt controller modules
package mic_pkg;

   typedef enum logic [1:0]
   {
      MIC_WR_IDLE = 2'b01,
      MIC_WR_RESP = 2'b10
   } mic_wr_state_t;

   typedef enum logic [1:0]
   {
      MIC_RD_IDLE = 2'b01,
      MIC_RD_RESP = 2'b10
   } mic_rd_state_t;

   typedef struct packed {
      logic [5:0] stage1;
      logic [5:0] stage2;
   } mic_sync_state_t;

   typedef struct packed {
      logic [5:0] prev;
      logic [2:0] armed;
   } mic_edge_state_t;

   typedef struct packed {
      mic_wr_state_t wr_state;
      mic_rd_state_t rd_state;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic wstrb0;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] flags;
      logic [2:0] enables;
      logic ext_irq_select;
      logic global_irq_enable;
      logic [5:0] port_change_select;
      logic ext_irq_edge;
      logic vector_valid;
      logic [8:0] vector_addr;
   } mic_core_state_t;

endpackage

// file: design/mic_pin_sync.sv
// Two-stage synchroniser for the port pins
`timescale 1ns/1ps
module mic_pin_sync
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Pins and synchronised copy
   input wire logic [5:0] pin_async,
   output logic [5:0] pin_sync
);

   mic_pkg::mic_sync_state_t q;
   mic_pkg::mic_sync_state_t d;

   always_comb
   begin
      d = q;
      d.stage1 = pin_async;
      d.stage2 = q.stage1;
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign pin_sync = q.stage2;

endmodule

// file: design/mic_pin_edge.sv
// Per-pin change, rising and falling edge detector on synchronised samples
`timescale 1ns/1ps
module mic_pin_edge
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Synchronised samples
   input wire logic [5:0] pin_sync,
   // One-cycle event pulses
   output logic [5:0] pin_change,
   output logic [5:0] pin_rise,
   output logic [5:0] pin_fall
);

   mic_pkg::mic_edge_state_t q;
   mic_pkg::mic_edge_state_t d;

   always_comb
   begin
      d = q;
      d.prev = pin_sync;
      d.armed = {q.armed[1:0], 1'b1};
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // Synchroniser restarts from zero, so no events until prev holds a real pin sample
   genvar i;
   generate
      for (i = 0; i < 6; i++)
      begin : g_bit
         assign pin_change[i] = q.armed[2] & (pin_sync[i] ^ q.prev[i]);
         assign pin_rise[i] = q.armed[2] & pin_sync[i] & ~q.prev[i];
         assign pin_fall[i] = q.armed[2] & ~pin_sync[i] & q.prev[i];
      end
   endgenerate

endmodule

// file: design/mic_irq_ctrl.sv
// Interrupt controller: flags, enables, global enable, vector selection, AXI4-Lite registers
//
// Functional notes
// - Soft-trap instruction always raises a software interrupt, no enable needed.
// - After soft trap the next fetch is from vector 0x001 regardless of global enable.
// - Taking the soft trap clears the global enable.
// - Hardware interrupts are taken only while the global enable is one.
// - Enable instruction sets the global enable, disable instruction clears it.
// - Return-from-interrupt sets the global enable and resumes the old sequence.
// - Each hardware event sets its own flag bit.
// - A flag stays set until firmware writes zero to it.
// - A flag reads as set in the flag register only while its enable bit is one; the status register shows it regardless.
// - Flag, enable and global enable all set take an interrupt to 0x008.
// - Taking a hardware interrupt clears the global enable.
// - Enable instruction inside a service routine permits nested interrupts.
// - Timer overflow past 0xff sets the timer overflow flag.
// - Timer request serviced only with its enable and the global enable.
// - Level change on selected input pins 0 to 5 sets the port change flag.
// - Port change request serviced only with its enable and the global enable.
// - External select disables change detection on pin 0 only.
// - Selected edge on pin 0 sets the external interrupt flag.
// - External request serviced only with its enable and the global enable.
// - Timer overflow flag is bit 0 of the flag register.
// - Port change flag and enable are bit 1; global enable is bit 7.
// - External select is bit 6 of the power control register.
`timescale 1ns/1ps
`include "mic_defines.svh"
module mic_irq_ctrl
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Instruction sequencer strobes
   input wire logic instr_boundary,
   input wire logic soft_trap_instr,
   input wire logic irq_enable_instr,
   input wire logic irq_disable_instr,
   input wire logic return_from_irq_instr,
   // Peripheral events and pins
   input wire logic timer_zero_overflow,
   input wire logic [5:0] port_dir_in,
   input wire logic [5:0] port_pin_n,
   // Vector and status towards the core
   output logic vector_valid,
   output logic [8:0] vector_addr,
   output logic global_irq_enable,
   output logic hw_irq_pending
);

   mic_pkg::mic_core_state_t q;
   mic_pkg::mic_core_state_t d;

   logic [5:0] pin_sync;
   logic [5:0] pin_change;
   logic [5:0] pin_rise;
   logic [5:0] pin_fall;
   logic [5:0] change_mask;
   logic [2:0] set_vec;
   logic [2:0] pending;
   logic port_change_evt;
   logic ext_edge_evt;
   logic take_soft;
   logic take_hw;
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic wr_fire;
   logic wr_ok;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;
   logic [31:0] rd_word;
   logic rd_hit;

   mic_pin_sync u_sync
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .pin_async(port_pin_n),
      .pin_sync(pin_sync)
   );

   mic_pin_edge u_edge
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .pin_sync(pin_sync),
      .pin_change(pin_change),
      .pin_rise(pin_rise),
      .pin_fall(pin_fall)
   );

   // Pin 0 leaves change detection while it serves as external input
   assign change_mask = port_dir_in & q.port_change_select
                        & ~{5'h00, q.ext_irq_select};
   assign port_change_evt = |(pin_change & change_mask);
   assign ext_edge_evt = q.ext_irq_select
                         & (q.ext_irq_edge ? pin_fall[0] : pin_rise[0]);

   // Event positions in the flag register
   always_comb
   begin
      set_vec = 3'h0;
      set_vec[`MIC_BIT_TIMER] = timer_zero_overflow;
      set_vec[`MIC_BIT_PORT] = port_change_evt;
      set_vec[`MIC_BIT_EXT] = ext_edge_evt;
   end

   // Requests that may interrupt, each gated by its own enable
   assign pending = q.flags & q.enables;
   assign take_soft = soft_trap_instr;
   // Soft trap has precedence; hardware waits for a boundary with global enable
   assign take_hw = instr_boundary & q.global_irq_enable & (|pending)
                    & ~soft_trap_instr;

   // Bus handshakes
   assign s_axi_awready = (q.wr_state == mic_pkg::MIC_WR_IDLE) & ~q.aw_got;
   assign s_axi_wready = (q.wr_state == mic_pkg::MIC_WR_IDLE) & ~q.w_got;
   assign s_axi_bvalid = (q.wr_state == mic_pkg::MIC_WR_RESP);
   assign s_axi_arready = (q.rd_state == mic_pkg::MIC_RD_IDLE);
   assign s_axi_rvalid = (q.rd_state == mic_pkg::MIC_RD_RESP);
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire = s_axi_wvalid & s_axi_wready;
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   assign wr_fire = (q.wr_state == mic_pkg::MIC_WR_IDLE) & q.aw_got & q.w_got;
   assign wr_addr = {q.awaddr[7:2], 2'b00};
   assign rd_addr = {s_axi_araddr[7:2], 2'b00};
   assign wr_ok = wr_fire & q.wstrb0;

   // Read mux
   always_comb
   begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      case (rd_addr)
         `MIC_OFF_FLAG:
         begin
            rd_word[2:0] = q.flags & q.enables;
         end
         `MIC_OFF_ENABLE:
         begin
            rd_word[2:0] = q.enables;
         end
         `MIC_OFF_PWR_CTRL:
         begin
            rd_word[`MIC_BIT_EXT_SEL] = q.ext_irq_select;
         end
         `MIC_OFF_PWR_CTRL_ONE:
         begin
            rd_word[`MIC_BIT_GIE] = q.global_irq_enable;
         end
         `MIC_OFF_CHG_SEL:
         begin
            rd_word[5:0] = q.port_change_select;
         end
         `MIC_OFF_EXT_EDGE:
         begin
            rd_word[`MIC_BIT_EDGE] = q.ext_irq_edge;
         end
         `MIC_OFF_STATUS:
         begin
            rd_word[2:0] = q.flags;
            rd_word[`MIC_BIT_STAT_GIE] = q.global_irq_enable;
            rd_word[`MIC_BIT_STAT_PEND] = |pending;
         end
         default:
         begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // Next state
   always_comb
   begin
      d = q;
      d.vector_valid = 1'b0;

      if (aw_fire)
      begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (w_fire)
      begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata[7:0];
         d.wstrb0 = s_axi_wstrb[0];
      end

      case (q.wr_state)
         mic_pkg::MIC_WR_IDLE:
         begin
            if (wr_fire)
            begin
               d.aw_got = 1'b0;
               d.w_got = 1'b0;
               d.wr_state = mic_pkg::MIC_WR_RESP;
               d.bresp = `MIC_RESP_OKAY;
               case (wr_addr)
                  `MIC_OFF_FLAG,
                  `MIC_OFF_ENABLE,
                  `MIC_OFF_PWR_CTRL,
                  `MIC_OFF_PWR_CTRL_ONE,
                  `MIC_OFF_CHG_SEL,
                  `MIC_OFF_EXT_EDGE,
                  `MIC_OFF_STATUS:
                  begin
                     d.bresp = `MIC_RESP_OKAY;
                  end
                  default:
                  begin
                     d.bresp = `MIC_RESP_SLVERR;
                  end
               endcase
            end
         end
         mic_pkg::MIC_WR_RESP:
         begin
            if (s_axi_bready)
            begin
               d.wr_state = mic_pkg::MIC_WR_IDLE;
            end
         end
         default:
         begin
            d.wr_state = mic_pkg::MIC_WR_IDLE;
         end
      endcase

      case (q.rd_state)
         mic_pkg::MIC_RD_IDLE:
         begin
            if (ar_fire)
            begin
               d.rd_state = mic_pkg::MIC_RD_RESP;
               d.rdata = rd_word;
               d.rresp = rd_hit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
            end
         end
         mic_pkg::MIC_RD_RESP:
         begin
            if (s_axi_rready)
            begin
               d.rd_state = mic_pkg::MIC_RD_IDLE;
            end
         end
         default:
         begin
            d.rd_state = mic_pkg::MIC_RD_IDLE;
         end
      endcase

      // Configuration writes from software
      if (wr_ok && (wr_addr == `MIC_OFF_ENABLE))
      begin
         d.enables = q.wdata[2:0];
      end
      if (wr_ok && (wr_addr == `MIC_OFF_PWR_CTRL))
      begin
         d.ext_irq_select = q.wdata[`MIC_BIT_EXT_SEL];
      end
      if (wr_ok && (wr_addr == `MIC_OFF_CHG_SEL))
      begin
         d.port_change_select = q.wdata[5:0];
      end
      if (wr_ok && (wr_addr == `MIC_OFF_EXT_EDGE))
      begin
         d.ext_irq_edge = q.wdata[`MIC_BIT_EDGE];
      end

      // Flags: writing zero clears, writing one keeps; a new event wins
      if (wr_ok && (wr_addr == `MIC_OFF_FLAG))
      begin
         d.flags = q.flags & q.wdata[2:0];
      end
      d.flags = d.flags | set_vec;

      // Global enable: later assignments take precedence
      if (wr_ok && (wr_addr == `MIC_OFF_PWR_CTRL_ONE))
      begin
         d.global_irq_enable = q.wdata[`MIC_BIT_GIE];
      end
      if (irq_enable_instr)
      begin
         d.global_irq_enable = 1'b1;
      end
      if (return_from_irq_instr)
      begin
         d.global_irq_enable = 1'b1;
      end
      if (irq_disable_instr)
      begin
         d.global_irq_enable = 1'b0;
      end

      // Vector selection
      if (take_soft)
      begin
         d.vector_valid = 1'b1;
         d.vector_addr = `MIC_VEC_SOFT;
         d.global_irq_enable = 1'b0;
      end
      else if (take_hw)
      begin
         d.vector_valid = 1'b1;
         d.vector_addr = `MIC_VEC_HW;
         d.global_irq_enable = 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         q.wr_state <= mic_pkg::MIC_WR_IDLE;
         q.rd_state <= mic_pkg::MIC_RD_IDLE;
         q.aw_got <= 1'b0;
         q.w_got <= 1'b0;
         q.awaddr <= 8'h00;
         q.wdata <= 8'h00;
         q.wstrb0 <= 1'b0;
         q.bresp <= `MIC_RESP_OKAY;
         q.rdata <= 32'h00000000;
         q.rresp <= `MIC_RESP_OKAY;
         q.flags <= `MIC_RST_FLAGS;
         q.enables <= `MIC_RST_ENABLES;
         q.ext_irq_select <= 1'b0;
         q.global_irq_enable <= 1'b0;
         q.port_change_select <= `MIC_RST_CHG_SEL;
         q.ext_irq_edge <= 1'b0;
         q.vector_valid <= 1'b0;
         q.vector_addr <= `MIC_RST_VECTOR;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs
   assign s_axi_bresp = q.bresp;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign vector_valid = q.vector_valid;
   assign vector_addr = q.vector_addr;
   assign global_irq_enable = q.global_irq_enable;
   assign hw_irq_pending = |pending;

endmodule

// file: tb/mic_core_model.sv
// Behavioural sequencer of the processor core beside the controller
`timescale 1ns/1ps
module mic_core_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Boundary spacing, zero keeps the core in one long instruction
   input wire logic [3:0] gap,
   // Vector request
   input wire logic vector_valid,
   input wire logic [8:0] vector_addr,
   // Boundary strobe and fetch record
   output logic instr_boundary,
   output logic [7:0] vec_count,
   output logic [8:0] last_vec
);
   logic [3:0] cnt_q;
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         cnt_q <= 4'h0;
         instr_boundary <= 1'b0;
         vec_count <= 8'h00;
         last_vec <= 9'h000;
      end
      else
      begin
         cnt_q <= (cnt_q >= gap) ? 4'h0 : cnt_q + 4'h1;
         // A vector fetch is not a boundary
         instr_boundary <= (gap != 4'h0) && (cnt_q == 4'h0) && !vector_valid;
         if (vector_valid)
         begin
            vec_count <= vec_count + 8'h01;
            last_vec <= vector_addr;
         end
      end
   end
endmodule

// file: tb/mic_irq_ctrl_properties.sv
// Port checks of the interrupt controller
`timescale 1ns/1ps
`include "mic_defines.svh"
module mic_irq_props
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Write response
   input wire logic s_axi_bvalid,
   // Core strobes
   input wire logic instr_boundary,
   input wire logic soft_trap_instr,
   input wire logic irq_enable_instr,
   input wire logic irq_disable_instr,
   input wire logic return_from_irq_instr,
   // Vector and status
   input wire logic vector_valid,
   input wire logic [8:0] vector_addr,
   input wire logic global_irq_enable,
   input wire logic hw_irq_pending
);
   wire logic take = instr_boundary && global_irq_enable && hw_irq_pending;
   wire logic quiet = !take && !soft_trap_instr && !irq_disable_instr;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_take;
      take && !soft_trap_instr;
   endsequence
   sequence s_hw_vec;
      vector_valid && vector_addr == `MIC_VEC_HW && !global_irq_enable;
   endsequence
   a_soft_vector: assert property (soft_trap_instr |=> vector_valid && vector_addr == `MIC_VEC_SOFT)
      else $error("soft trap vector wrong");
   a_soft_gie_clr: assert property (soft_trap_instr |=> !global_irq_enable)
      else $error("soft trap left global enable set");
   a_hw_take: assert property (s_take |=> s_hw_vec)
      else $error("hardware take wrong");
   a_gie_gate: assert property (!global_irq_enable && !soft_trap_instr |=> !vector_valid)
      else $error("vector with global enable clear");
   a_gie_set: assert property ((irq_enable_instr || return_from_irq_instr) && quiet |=> global_irq_enable)
      else $error("global enable not set");
   a_gie_clear: assert property (irq_disable_instr |=> !global_irq_enable)
      else $error("global enable not cleared");
   a_pending_hold: assert property (hw_irq_pending ##1 !$rose(s_axi_bvalid) |-> hw_irq_pending)
      else $error("pending request lost without a write");
   a_vec_cause: assert property (vector_valid |-> $past(soft_trap_instr) || $past(instr_boundary))
      else $error("vector without trap or boundary");
endmodule
bind mic_irq_ctrl mic_irq_props mic_irq_props_inst (.core_clk(core_clk), .resetn(resetn),
   .s_axi_bvalid(s_axi_bvalid), .instr_boundary(instr_boundary), .soft_trap_instr(soft_trap_instr),
   .irq_enable_instr(irq_enable_instr), .irq_disable_instr(irq_disable_instr),
   .return_from_irq_instr(return_from_irq_instr), .vector_valid(vector_valid),
   .vector_addr(vector_addr), .global_irq_enable(global_irq_enable),
   .hw_irq_pending(hw_irq_pending));

// file: tb/mic_irq_ctrl_bench.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
`include "mic_defines.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module mic_irq_ctrl_bench;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h0, gap = 4'h0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, timer_zero_overflow = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   // Return, disable, enable, soft trap
   logic [3:0] strb = 4'h0;
   logic [5:0] port_dir_in = 6'h00, port_pin_n = 6'h00, sel;
   logic instr_boundary, vector_valid, global_irq_enable, hw_irq_pending;
   logic [8:0] vector_addr, last_vec;
   logic [7:0] vec_count, vc;
   integer seed;
   int err_count = 0, checked = 0, i, k;
   always #25 core_clk = ~core_clk;
   mic_irq_ctrl mic_irq_ctrl_inst (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .instr_boundary, .soft_trap_instr(strb[0]), .irq_enable_instr(strb[1]),
      .irq_disable_instr(strb[2]), .return_from_irq_instr(strb[3]), .timer_zero_overflow,
      .port_dir_in, .port_pin_n, .vector_valid, .vector_addr, .global_irq_enable, .hw_irq_pending);
   mic_core_model mic_core_model_inst (.core_clk, .resetn, .gap, .vector_valid, .vector_addr,
      .instr_boundary, .vec_count, .last_vec);
   function automatic logic [31:0] exp_flags(logic [2:0] raw, logic [2:0] en);
      return {29'h0, raw & en};
   endfunction
   task wrap_up;
      if (err_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic pa, pw, ha, hw;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw)
      begin
         @(negedge core_clk);
         ha = pa && s_axi_awready;
         hw = pw && s_axi_wready;
         @(posedge core_clk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         pa = pa && !ha;
         pw = pw && !hw;
      end
      do @(negedge core_clk); while (!s_axi_bvalid);
      `CHK("write response", er, s_axi_bresp)
      @(posedge core_clk);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge core_clk); while (!s_axi_arready);
      @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge core_clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      `CHK("read response", er, s_axi_rresp)
      @(posedge core_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
      axi_rd(a, `MIC_RESP_OKAY);
      `CHK("register read", ex, rd)
   endtask
   task automatic strobe(input logic [3:0] s);
      strb <= s;
      @(posedge core_clk);
      strb <= 4'h0;
      repeat (2) @(posedge core_clk);
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      wrap_up;
   end
   initial
   begin
      seed = 32'hbac4658b;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      for (i = 0; i < 8; i++)
      begin
         axi_rd(8'(i * 4), (i < 7) ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR);
         `CHK("reset value", 32'h0, rd)
      end
      axi_wr(8'h1c, 8'hff, `MIC_RESP_SLVERR);
      strobe(4'h2);
      rchk(8'h0c, 32'h80);
      strobe(4'h4);
      `CHK("global enable", 1'b0, global_irq_enable)
      timer_zero_overflow <= 1'b1;
      @(posedge core_clk);
      timer_zero_overflow <= 1'b0;
      rchk(8'h00, 32'h0);
      rchk(8'h18, 32'h1);
      axi_wr(8'h04, 8'h01, `MIC_RESP_OKAY);
      rchk(8'h00, exp_flags(3'b001, 3'b001));
      repeat ($unsigned($random(seed)) % 16) @(posedge core_clk);
      axi_wr(8'h00, 8'hff, `MIC_RESP_OKAY);
      rchk(8'h00, 32'h1);
      vc = vec_count;
      gap <= 4'h3;
      repeat (10) @(posedge core_clk);
      `CHK("vectors taken", vc, vec_count)
      gap <= 4'h0;
      strobe(4'h2);
      repeat (10) @(posedge core_clk);
      `CHK("vectors taken", vc, vec_count)
      gap <= 4'h3;
      repeat (8) @(posedge core_clk);
      `CHK("vectors taken", vc + 8'h01, vec_count)
      `CHK("hardware vector", `MIC_VEC_HW, last_vec)
      `CHK("global enable", 1'b0, global_irq_enable)
      strobe(4'h2);
      repeat (8) @(posedge core_clk);
      `CHK("vectors taken", vc + 8'h02, vec_count)
      axi_wr(8'h00, 8'hfe, `MIC_RESP_OKAY);
      strobe(4'h8);
      repeat (8) @(posedge core_clk);
      `CHK("global enable", 1'b1, global_irq_enable)
      for (k = 0; k < 2; k++)
      begin
         axi_wr(8'h0c, (k == 1) ? 8'h80 : 8'h00, `MIC_RESP_OKAY);
         vc = vec_count;
         strobe(4'h1);
         `CHK("vectors taken", vc + 8'h01, vec_count)
         `CHK("soft vector", `MIC_VEC_SOFT, last_vec)
         `CHK("global enable", 1'b0, global_irq_enable)
      end
      gap <= 4'h0;
      axi_wr(8'h04, 8'h07, `MIC_RESP_OKAY);
      for (i = 0; i < 6; i++)
      begin
         sel = 6'($random(seed));
         k = $unsigned($random(seed)) % 6;
         port_dir_in <= 6'($random(seed));
         axi_wr(8'h10, {2'b00, sel}, `MIC_RESP_OKAY);
         axi_wr(8'h00, 8'h00, `MIC_RESP_OKAY);
         port_pin_n[k] <= ~port_pin_n[k];
         repeat (5) @(posedge core_clk);
         rchk(8'h00, exp_flags({1'b0, sel[k] & port_dir_in[k], 1'b0}, 3'b111));
      end
      port_dir_in <= 6'h3f;
      axi_wr(8'h08, 8'h40, `MIC_RESP_OKAY);
      axi_wr(8'h10, 8'h03, `MIC_RESP_OKAY);
      for (k = 0; k < 2; k++)
      begin
         axi_wr(8'h14, 8'(k), `MIC_RESP_OKAY);
         port_pin_n[0] <= k[0];
         repeat (5) @(posedge core_clk);
         axi_wr(8'h00, 8'h00, `MIC_RESP_OKAY);
         port_pin_n[1:0] <= ~port_pin_n[1:0];
         repeat (5) @(posedge core_clk);
         rchk(8'h00, exp_flags(3'b110, 3'b111));
         `CHK("pending", 1'b1, hw_irq_pending)
         axi_wr(8'h00, 8'h00, `MIC_RESP_OKAY);
         port_pin_n[0] <= k[0];
         repeat (5) @(posedge core_clk);
         rchk(8'h00, 32'h0);
      end
      wrap_up;
   end
endmodule
